//--- core/scc_core.sv
/*
  stepper chopper control core: two coil constant current chopper with
  mixed decay, torque scaling, fault blanking and latching, and a small
  register file with interrupt.
  assumes all pin inputs are asynchronous to clk_sys_i and that the
  chop oscillator runs well below half of the 10 MHz system clock.
*/
// Behaviour
// [R1] mixed decay only, fast decay 31.25%
// [R2] period starts in charge at count zero
// [R3] limit detect in charge moves to slow
// [R4] eleventh chop clock moves to fast decay
// [R5] sixteenth chop clock restarts period in charge
// [R6] torque code scales both coil currents
// [R7] direction high positive, low negative current
// [R8] drive off gives zero current
// [R9] overcurrent blanked seven to eight fault clocks
// [R10] thermal blanked fifteen to sixteen fault clocks
// [R11] any trip turns all gate outputs and coil phases off
// [R12] trip latched until standby or power cycle
// [R13] other torque codes from lookup table
`timescale 1ns/1ns
module scc_core
  import scc_pkg::*;
(
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  // register port
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  output logic irq_o,
  // control pins
  input wire logic chop_oscillator_clock_i,
  input wire logic standby_i,
  input wire logic [1:0] coil_dir_i,
  input wire logic [1:0] coil_on_i,
  input wire logic torque_code_bit1_i,
  input wire logic torque_code_bit2_i,
  input wire logic torque_code_bit3_i,
  input wire logic torque_code_bit4_i,
  // detector pins
  input wire logic [1:0] current_limit_detect_i,
  input wire logic overcurrent_shutdown_i,
  input wire logic thermal_shutdown_i,
  // bridge side, per coil {hs_pos, ls_pos, hs_neg, ls_neg}
  output logic [7:0] coil_gate_o,
  output logic [1:0] coil_sign_o,
  output logic [13:0] coil_ref_pct_o,
  output logic [3:0] coil_phase_o,
  output logic fault_o
);

  // two flop input synchroniser
  localparam int SYNC_W = 14;
  logic [SYNC_W-1:0] pin_meta_r;
  logic [SYNC_W-1:0] pin_sync_r;
  wire [SYNC_W-1:0] pin_raw = {chop_oscillator_clock_i, standby_i,
    coil_dir_i, coil_on_i, torque_code_bit1_i, torque_code_bit2_i,
    torque_code_bit3_i, torque_code_bit4_i, current_limit_detect_i,
    overcurrent_shutdown_i, thermal_shutdown_i};

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pin_meta_r <= '0;
      pin_sync_r <= '0;
    end else begin
      pin_meta_r <= pin_raw;
      pin_sync_r <= pin_meta_r;
    end
  end

  wire chop_s = pin_sync_r[13];
  wire standby_s = pin_sync_r[12];
  wire [1:0] dir_s = pin_sync_r[11:10];
  wire [1:0] on_s = pin_sync_r[9:8];
  wire [3:0] torque_s = pin_sync_r[7:4];
  wire [1:0] limit_s = pin_sync_r[3:2];
  wire ovc_s = pin_sync_r[1];
  wire therm_s = pin_sync_r[0];

  // chop oscillator edge and period counter
  logic chop_prev_r;
  logic [3:0] chop_cnt_r;
  wire chop_edge = chop_s & ~chop_prev_r;
  wire period_start = chop_edge && (chop_cnt_r == CHOP_LAST_CNT); // see [R5]
  wire fast_start = chop_edge && (chop_cnt_r == CHOP_FAST_CNT); // see [R4]

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      chop_prev_r <= 1'b0;
      chop_cnt_r <= 4'h0;
    end else begin
      chop_prev_r <= chop_s;
      if (chop_edge) begin
        chop_cnt_r <= chop_cnt_r + 4'h1; // see [R5]
      end
    end
  end

  // internal fault oscillator as a phase accumulator tick
  logic [FAULT_ACC_W-1:0] fault_acc_r;
  wire [FAULT_ACC_W:0] fault_acc_sum = {1'b0, fault_acc_r} +
    {1'b0, FAULT_ACC_INC};
  wire fault_tick = fault_acc_sum[FAULT_ACC_W];

  // blanking counters and trip latches
  logic [3:0] ovc_cnt_r;
  logic [4:0] therm_cnt_r;
  logic ovc_trip_r;
  logic therm_trip_r;
  wire ovc_hit = ovc_s && fault_tick &&
    (ovc_cnt_r == OVC_BLANK_TICKS - 4'h1); // see [R9]
  wire therm_hit = therm_s && fault_tick &&
    (therm_cnt_r == THERM_BLANK_TICKS - 5'h01); // see [R10]
  wire fault = ovc_trip_r | therm_trip_r;

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      fault_acc_r <= '0;
      ovc_cnt_r <= 4'h0;
      therm_cnt_r <= 5'h00;
      ovc_trip_r <= 1'b0;
      therm_trip_r <= 1'b0;
    end else begin
      fault_acc_r <= fault_acc_sum[FAULT_ACC_W-1:0];
      if (!ovc_s) begin
        ovc_cnt_r <= 4'h0; // see [R9]
      end else if (fault_tick && ovc_cnt_r != OVC_BLANK_TICKS) begin
        ovc_cnt_r <= ovc_cnt_r + 4'h1;
      end
      if (!therm_s) begin
        therm_cnt_r <= 5'h00; // see [R10]
      end else if (fault_tick && therm_cnt_r != THERM_BLANK_TICKS) begin
        therm_cnt_r <= therm_cnt_r + 5'h01;
      end
      // set wins over the standby clear
      if (ovc_hit) begin
        ovc_trip_r <= 1'b1;
      end else if (standby_s) begin
        ovc_trip_r <= 1'b0; // see [R12]
      end
      if (therm_hit) begin
        therm_trip_r <= 1'b1;
      end else if (standby_s) begin
        therm_trip_r <= 1'b0; // see [R12]
      end
    end
  end

  // register file
  logic drive_en_r;
  logic [IRQ_W-1:0] irq_en_r;
  logic [IRQ_W-1:0] irq_stat_r;
  wire wr_ctrl = wr_i && (addr_i == CTRL_OFS);
  wire wr_clr = wr_i && (addr_i == IRQ_CLR_OFS);
  wire wr_en = wr_i && (addr_i == IRQ_EN_OFS);
  wire [IRQ_W-1:0] irq_event = {period_start, therm_hit & ~therm_trip_r,
    ovc_hit & ~ovc_trip_r};
  wire [IRQ_W-1:0] irq_clr = wr_clr ? wdata_i[IRQ_W-1:0] : '0;
  wire [31:0] status_word = {24'h000000, chop_cnt_r, therm_trip_r,
    ovc_trip_r, standby_s, drive_en_r};
  wire [31:0] rd_mux =
    (addr_i == CTRL_OFS) ? {31'h0, drive_en_r} :
    (addr_i == STATUS_OFS) ? status_word :
    (addr_i == IRQ_STAT_OFS) ? {29'h0, irq_stat_r} :
    (addr_i == IRQ_EN_OFS) ? {29'h0, irq_en_r} : 32'h00000000;

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      drive_en_r <= CTRL_DRIVE_EN_RST;
      irq_en_r <= IRQ_EN_RST;
      irq_stat_r <= '0;
      rdata_o <= 32'h00000000;
    end else begin
      if (wr_ctrl) begin
        drive_en_r <= wdata_i[CTRL_DRIVE_EN_BIT];
      end
      if (wr_en) begin
        irq_en_r <= wdata_i[IRQ_W-1:0];
      end
      irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_event;
      rdata_o <= rd_i ? rd_mux : 32'h00000000;
    end
  end

  assign irq_o = |(irq_stat_r & irq_en_r);
  assign fault_o = fault;

  // torque scaling
  wire [PCT_W-1:0] torque_pct = TORQUE_PCT[torque_s]; // see [R6] [R13]
  wire run_ok = drive_en_r && !standby_s && !fault; // see [R11]

  // per coil chopper
  scc_phase_type phase_r [2];
  genvar gc;
  generate
    for (gc = 0; gc < 2; gc++) begin : g_coil
      scc_phase_type phase_nxt;
      logic [3:0] gate_nxt;
      logic [3:0] gate_r;
      logic sign_r;
      logic [PCT_W-1:0] pct_r;
      wire coil_run = run_ok && on_s[gc];

      always_comb begin
        phase_nxt = phase_r[gc];
        if (!coil_run) begin
          phase_nxt = PH_OFF; // see [R8] [R11]
        end else if (period_start) begin
          phase_nxt = PH_CHARGE; // see [R2] [R5]
        end else if (fast_start) begin
          phase_nxt = PH_FAST; // see [R1] [R4]
        end else if (phase_r[gc] == PH_CHARGE && limit_s[gc]) begin
          phase_nxt = PH_SLOW; // see [R3]
        end
      end

      // charge drives along the sign, fast decay against it
      always_comb begin
        unique case (phase_r[gc])
          PH_OFF: gate_nxt = 4'h0;
          PH_CHARGE: gate_nxt = dir_s[gc] ? 4'h9 : 4'h6; // see [R7]
          PH_SLOW: gate_nxt = 4'h5;
          PH_FAST: gate_nxt = dir_s[gc] ? 4'h6 : 4'h9; // see [R1]
        endcase
      end

      always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
          phase_r[gc] <= PH_OFF;
          gate_r <= 4'h0;
          sign_r <= 1'b0;
          pct_r <= PCT_ZERO;
        end else begin
          phase_r[gc] <= phase_nxt;
          gate_r <= fault ? 4'h0 : gate_nxt; // see [R11]
          sign_r <= dir_s[gc]; // see [R7]
          pct_r <= on_s[gc] ? torque_pct : PCT_ZERO; // see [R6] [R8]
        end
      end

      assign coil_gate_o[4*gc+3:4*gc] = gate_r;
      assign coil_sign_o[gc] = sign_r;
      assign coil_ref_pct_o[PCT_W*gc+PCT_W-1:PCT_W*gc] = pct_r;
      assign coil_phase_o[2*gc+1:2*gc] = phase_r[gc];
    end
  endgenerate

  // checks
  sequence s_wrap;
    chop_edge && chop_cnt_r == CHOP_LAST_CNT;
  endsequence

  sequence s_restart(int c);
    chop_cnt_r == 4'h0 && phase_r[c] == PH_CHARGE;
  endsequence

  property p_restart_charge;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      s_wrap ##0 (run_ok && on_s[0]) |=> s_restart(0);
  endproperty
  a_restart_charge: assert property (p_restart_charge) // see [R2] [R5]
    else $error("period restart did not enter charge");
  property p_fast_eleventh;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      fast_start && run_ok && on_s[1] |=>
        phase_r[1] == PH_FAST && chop_cnt_r == 4'hB;
  endproperty
  a_fast_eleventh: assert property (p_fast_eleventh) // see [R4] [R1]
    else $error("fast decay not entered on eleventh chop clock");
  property p_limit_slow;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      phase_r[0] == PH_CHARGE && limit_s[0] && run_ok && on_s[0] &&
      !chop_edge |=> phase_r[0] == PH_SLOW;
  endproperty
  a_limit_slow: assert property (p_limit_slow) // see [R3]
    else $error("limit detect did not end charge");
  property p_torque_full;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      torque_s == 4'hF && on_s[0] |=> coil_ref_pct_o[6:0] == 7'h64;
  endproperty
  a_torque_full: assert property (p_torque_full) // see [R6]
    else $error("full torque code not 100 percent");
  property p_off_zero;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      !on_s[1] |=> coil_ref_pct_o[13:7] == PCT_ZERO &&
        phase_r[1] == PH_OFF ##1 coil_gate_o[7:4] == 4'h0;
  endproperty
  a_off_zero: assert property (p_off_zero) // see [R8]
    else $error("coil off but current not zero");
  property p_sign;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      phase_r[0] == PH_CHARGE && !fault |=>
        coil_gate_o[3:0] == ($past(dir_s[0]) ? 4'h9 : 4'h6);
  endproperty
  a_sign: assert property (p_sign) // see [R7]
    else $error("charge polarity does not follow direction");
  property p_ovc_blank;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      $rose(ovc_trip_r) |-> $past(ovc_cnt_r) == 4'h7 && $past(ovc_s);
  endproperty
  a_ovc_blank: assert property (p_ovc_blank) // see [R9]
    else $error("overcurrent tripped without full blanking");
  property p_therm_blank;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      $rose(therm_trip_r) |-> $past(therm_cnt_r) == 5'h0F &&
        $past(therm_s);
  endproperty
  a_therm_blank: assert property (p_therm_blank) // see [R10]
    else $error("thermal tripped without full blanking");
  property p_fault_off;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      fault |=> coil_gate_o == 8'h00 && phase_r[0] == PH_OFF &&
        phase_r[1] == PH_OFF;
  endproperty
  a_fault_off: assert property (p_fault_off) // see [R11]
    else $error("outputs still on after fault");
  property p_latch;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      ovc_trip_r && !standby_s |=> ovc_trip_r;
  endproperty
  a_latch: assert property (p_latch) // see [R12]
    else $error("fault latch cleared without standby");

  property p_wrap_zero;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      s_wrap |=> chop_cnt_r == 4'h0;
  endproperty
  a_wrap_zero: assert property (p_wrap_zero) // see [R5]
    else $error("period counter did not wrap after sixteen");

endmodule // scc_core

//--- core/scc_pkg.sv
/*
  constants for the stepper chopper control core: register map, reset
  values, chopper counts, fault blanking counts and the torque table.
  assumes a single 10 MHz system clock.
*/
package scc_pkg;

  // system clock and internal fault oscillator
  localparam int SYS_CLK_KHZ = 10000;
  localparam int FAULT_OSC_KHZ = 6400;
  localparam int FAULT_ACC_W = 10;
  localparam logic [FAULT_ACC_W-1:0] FAULT_ACC_INC =
    FAULT_ACC_W'((FAULT_OSC_KHZ * (2 ** FAULT_ACC_W)) / SYS_CLK_KHZ);

  // chopping period in chop oscillator clocks
  localparam logic [3:0] CHOP_LAST_CNT = 4'hF;
  localparam logic [3:0] CHOP_FAST_CNT = 4'hA;

  // fault blanking in fault oscillator clocks
  localparam logic [3:0] OVC_BLANK_TICKS = 4'h8;
  localparam logic [4:0] THERM_BLANK_TICKS = 5'h10;

  // register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h08;
  localparam logic [7:0] IRQ_CLR_OFS = 8'h0C;
  localparam logic [7:0] IRQ_EN_OFS = 8'h10;

  // control fields and reset values
  localparam int CTRL_DRIVE_EN_BIT = 0;
  localparam logic CTRL_DRIVE_EN_RST = 1'b0;
  localparam int IRQ_W = 3;
  localparam int IRQ_OVC_BIT = 0;
  localparam int IRQ_THERM_BIT = 1;
  localparam int IRQ_PERIOD_BIT = 2;
  localparam logic [IRQ_W-1:0] IRQ_EN_RST = 3'h0;

  // percent of full scale per torque code {bit1,bit2,bit3,bit4}
  localparam int PCT_W = 7;
  localparam logic [PCT_W-1:0] PCT_ZERO = 7'h00;
  localparam logic [PCT_W-1:0] TORQUE_PCT [16] = '{
    7'h00, 7'h07, 7'h0D, 7'h13, 7'h19, 7'h1F, 7'h26, 7'h2C,
    7'h32, 7'h3C, 7'h3F, 7'h45, 7'h4B, 7'h51, 7'h58, 7'h64
  };

  // coil phase
  typedef enum logic [1:0] {
    PH_OFF = 2'b00,
    PH_CHARGE = 2'b01,
    PH_SLOW = 2'b10,
    PH_FAST = 2'b11
  } scc_phase_type;

endpackage

//--- test/scc_coil_model.sv
/*
  coil model: current grows while a bridge charges the coil, holds in slow
  decay and falls otherwise; the limit detect rises once it reaches lim_i.
  assumes the gate and sign coding of the chopper core and one clock.
*/
`timescale 1ns/1ns
module scc_coil_model (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  // bridge side
  input wire logic [7:0] coil_gate_i,
  input wire logic [1:0] coil_sign_i,
  input wire logic [15:0] lim_i,
  // sense side
  output logic [1:0] current_limit_detect_o
);
  logic [15:0] mag_r [2];
  wire [1:0] chg = {coil_gate_i[7:4] == (coil_sign_i[1] ? 4'h9 : 4'h6),
    coil_gate_i[3:0] == (coil_sign_i[0] ? 4'h9 : 4'h6)};
  wire [1:0] hold = {coil_gate_i[7:4] == 4'h5, coil_gate_i[3:0] == 4'h5};
  always @(posedge clk_sys_i or negedge rstn_i) begin
    for (int c = 0; c < 2; c++) begin
      if (!rstn_i) begin
        mag_r[c] <= 16'h0000;
      end else if (chg[c]) begin
        mag_r[c] <= mag_r[c] + 16'h0001;
      end else if (!hold[c] && mag_r[c] != 16'h0000) begin
        mag_r[c] <= mag_r[c] - 16'h0001;
      end
    end
  end
  assign current_limit_detect_o = {mag_r[1] >= lim_i, mag_r[0] >= lim_i};
endmodule // scc_coil_model

//--- test/tb_stepper_chopper_control.sv
/*
  bench for the chopper core: registers, torque and step tables, chopper
  phases, fault blanking and latching, interrupt.
  assumes the coil model closes the current loop; one 10 MHz clock.
*/
`timescale 1ns/1ns
module tb_stepper_chopper_control import scc_pkg::*;;
  logic clk_sys_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [7:0] addr_i, gate;
  logic [31:0] wdata_i, rdata_o, v;
  logic wr_i, rd_i, irq_o, chop_i, standby_i, ovc_i, therm_i, fault;
  logic [1:0] dir_i, on_i, lim_det, sign;
  logic [3:0] trq, phase;
  logic [13:0] pct;
  logic [15:0] lim;
  int err_count, checks, k, ph;
  logic [1:0] hon [8] = '{2'h3, 2'h2, 2'h3, 2'h1, 2'h3, 2'h2, 2'h3, 2'h1};
  logic [1:0] hdir [8] = '{2'h3, 2'h2, 2'h2, 2'h0, 2'h0, 2'h0, 2'h1, 2'h1};

  always #50 clk_sys_i = ~clk_sys_i;

  scc_core dut (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .irq_o(irq_o), .chop_oscillator_clock_i(chop_i), .standby_i(standby_i),
    .coil_dir_i(dir_i), .coil_on_i(on_i), .torque_code_bit1_i(trq[3]),
    .torque_code_bit2_i(trq[2]), .torque_code_bit3_i(trq[1]),
    .torque_code_bit4_i(trq[0]), .current_limit_detect_i(lim_det),
    .overcurrent_shutdown_i(ovc_i), .thermal_shutdown_i(therm_i),
    .coil_gate_o(gate), .coil_sign_o(sign), .coil_ref_pct_o(pct),
    .coil_phase_o(phase), .fault_o(fault));
  scc_coil_model coil (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
    .coil_gate_i(gate), .coil_sign_i(sign), .lim_i(lim),
    .current_limit_detect_o(lim_det));

  function automatic logic [6:0] exp_pct(int c);
    case (c)
      15: return 7'h64;
      9: return 7'h3C;
      4: return 7'h19;
      default: return TORQUE_PCT[c];
    endcase
  endfunction
  function automatic logic [3:0] exp_gate(int p, logic d);
    case (p)
      1: return d ? 4'h9 : 4'h6;
      2: return 4'h5;
      3: return d ? 4'h6 : 4'h9;
      default: return 4'h0;
    endcase
  endfunction

  task automatic stop_test();
    if (err_count == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk_out(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD out t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD reg t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge clk_sys_i);
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
    @(posedge clk_sys_i);
  endtask
  task automatic rdchk(logic [7:0] a, logic [31:0] e, logic [31:0] m);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    #1;
    v = rdata_o;
    @(posedge clk_sys_i);
    chk_reg(v & m, e);
  endtask
  task automatic step(int c, logic [1:0] on, logic [1:0] d);
    logic [1:0] dx;
    dx = d ^ (~on & 2'($urandom));
    trq <= 4'(c);
    on_i <= on;
    dir_i <= dx;
    tick(4);
    #1;
    chk_out(32'(sign), 32'(dx));
    chk_out(32'(pct), 32'({on[1] ? exp_pct(c) : 7'h00,
      on[0] ? exp_pct(c) : 7'h00}));
    @(posedge clk_sys_i);
  endtask
  task automatic chop_edge(int p);
    chop_i <= 1'b1;
    tick(4);
    chop_i <= 1'b0;
    tick(2);
    #1;
    if (p >= 0) begin
      chk_out(32'(phase), 32'({2{2'(p)}}));
      chk_out(32'(gate),
        32'({exp_gate(p, 1'b0), exp_gate(p, 1'b1)}));
    end
    @(posedge clk_sys_i);
    rdchk(STATUS_OFS, 32'((k % 16) << 4), 32'hF0);
  endtask
  task automatic fault_run(int w, int len, int lo, int hi);
    int n;
    n = 0;
    if (w == 0) ovc_i <= 1'b1; else therm_i <= 1'b1;
    tick(len);
    {ovc_i, therm_i} <= 2'b00;
    tick(14);
    #1;
    chk_out(32'(fault), 32'h0);
    @(posedge clk_sys_i);
    if (w == 0) ovc_i <= 1'b1; else therm_i <= 1'b1;
    while (fault !== 1'b1 && n < 40) begin
      @(posedge clk_sys_i);
      n++;
      #1;
    end
    if (n >= 40) begin
      err_count++;
      stop_test();
    end
    chk_out(32'(n >= lo && n <= hi), 32'h1);
    @(posedge clk_sys_i);
    {ovc_i, therm_i} <= 2'b00;
    tick(2);
    #1;
    chk_out(32'({gate, phase}), 32'h0);
    @(posedge clk_sys_i);
    wr(CTRL_OFS, 32'h1);
    tick(4);
    #1;
    chk_out(32'(fault), 32'h1);
    @(posedge clk_sys_i);
    rdchk(STATUS_OFS, 32'h4 << w, 32'hC);
    rdchk(IRQ_STAT_OFS, 32'h1 << w, 32'h1 << w);
    if (w == 0) standby_i <= 1'b1; else rstn_i <= 1'b0;
    tick(4);
    #1;
    chk_out(32'({fault, phase}), 32'h0);
    @(posedge clk_sys_i);
    {standby_i, rstn_i} <= 2'b01;
    tick(2);
  endtask

  initial begin
    {wr_i, rd_i, chop_i, standby_i, ovc_i, therm_i} = 6'h00;
    {addr_i, wdata_i, dir_i, on_i, trq} = '0;
    lim = 16'h03E8;
    err_count = 0;
    checks = 0;
    v = $urandom(39);
    tick(3);
    #1;
    chk_out(32'({gate, pct, phase, fault, irq_o}), 32'h0);
    @(posedge clk_sys_i);
    rstn_i <= 1'b1;
    @(posedge clk_sys_i);
    rdchk(STATUS_OFS, 32'h0, 32'hFF);
    rdchk(IRQ_EN_OFS, 32'(IRQ_EN_RST), 32'h7);
    wr(STATUS_OFS, 32'hFF);
    rdchk(STATUS_OFS, 32'h0, 32'hFF);
    rdchk(8'h14, 32'h0, 32'hFFFFFFFF);
    rdchk(IRQ_CLR_OFS, 32'h0, 32'hFFFFFFFF);
    for (int c = 0; c < 16; c++) step(c, 2'($urandom), 2'($urandom));
    for (int s = 0; s < 8; s++) begin
      step(s[0] ? 4 : (s[1] ? 9 : 15), hon[s], hdir[s]);
    end
    wr(CTRL_OFS, 32'h1);
    rdchk(STATUS_OFS, 32'h1, 32'h1);
    on_i <= 2'h3;
    dir_i <= 2'h1;
    for (k = 1; k <= 48; k++) begin
      lim <= k > 32 ? 16'h0003 : 16'h03E8;
      ph = (k % 16 >= 11) ? 3 : ((k > 32 && k % 16 != 0) ? 2 : 1);
      chop_edge((k <= 16 || (k > 32 && k % 16 == 0)) ? -1 : ph);
    end
    chk_out(32'(irq_o), 32'h0);
    rdchk(IRQ_STAT_OFS, 32'h4, 32'h4);
    wr(IRQ_EN_OFS, 32'h4);
    chk_out(32'(irq_o), 32'h1);
    wr(IRQ_CLR_OFS, 32'h4);
    chk_out(32'(irq_o), 32'h0);
    rdchk(IRQ_STAT_OFS, 32'h0, 32'h7);
    fault_run(0, 6, 10, 19);
    fault_run(1, 18, 21, 31);
    rdchk(CTRL_OFS, 32'(CTRL_DRIVE_EN_RST), 32'h1);
    stop_test();
  end
endmodule // tb_stepper_chopper_control
